// ==== irq_ack_pkg.sv ====
// constants and types shared by the interrupt acknowledge block
`default_nettype none
package irq_ack_pkg;
  localparam int NREQ = 24;                            // maskable request count
  // apb register byte offsets
  localparam logic [11:0] OFS_REQ     = 12'h000;       // request flags, w1c
  localparam logic [11:0] OFS_MASK    = 12'h004;       // mask flags
  localparam logic [11:0] OFS_MACRO   = 12'h008;       // macro service enables
  localparam logic [11:0] OFS_CTX     = 12'h00c;       // context switch enables
  localparam logic [11:0] OFS_LVL_LO  = 12'h010;       // level bit 0 per request
  localparam logic [11:0] OFS_LVL_HI  = 12'h014;       // level bit 1 per request
  localparam logic [11:0] OFS_MODE    = 12'h018;       // irq_mode_control
  localparam logic [11:0] OFS_STAT    = 12'h01c;       // in-service bits and enable
  localparam logic [11:0] OFS_MSC     = 12'h040;       // first macro counter
  localparam logic [11:0] OFS_MSC_END = 12'h0a0;       // past last macro counter
  // field positions
  localparam int MODE_NEST_BIT = 0;                    // level3_nesting_select
  localparam int STAT_IE_BIT   = 4;                    // enable flag in status
  // reset values
  localparam logic [NREQ-1:0] MASK_RST  = 24'hffffff;  // all requests masked
  localparam logic [NREQ-1:0] ZERO_RST  = 24'h000000;
  localparam logic [NREQ-1:0] ONE_LSB   = 24'h000001;
  localparam logic            NEST_RST  = 1'b1;
  localparam logic [3:0]      ISR_RST   = 4'h0;
  localparam logic [7:0]      MSC_RST   = 8'h00;
  // vector addresses
  localparam logic [15:0] BRK_VEC    = 16'h003e;       // stack trap entry
  localparam logic [15:0] OPTRAP_VEC = 16'h0002;       // op-code trap entry
  localparam logic [15:0] VEC_BASE   = 16'h0040;       // request 0 entry
  // instruction events from the core
  typedef enum logic [3:0] {
    OP_NONE, OP_EI, OP_DI, OP_STACK_IRQ_RET, OP_BANK_IRQ_RET, OP_SOFT_BANK_RET,
    OP_STACK_TRAP, OP_BANK_TRAP, OP_STACK_TRAP_RET, OP_PROT_WR
  } op_e;
  // actions ordered to the core
  typedef enum logic [3:0] {
    ACT_NONE, ACT_VEC_ENTRY, ACT_BANK_ENTRY, ACT_MACRO, ACT_STACK_RET,
    ACT_BANK_RET, ACT_STACK_TRAP, ACT_BANK_TRAP, ACT_OPTRAP
  } act_e;
endpackage
`default_nettype wire

// ==== irq_ack.sv ====
// maskable request acceptance, priority and entry/return sequencing
//
// Function
// R01 - candidate needs request set and mask clear
// R02 - macro immediate; others need enable and level
// R03 - highest level first, then default priority
// R04 - unaccepted requests stay pending until acceptable
// R05 - vectored entry: push, clear enable, set in-service
// R06 - four programmable levels plus fixed default order
// R07 - idle: enable gates maskable, macro always
// R08 - level 3 in service: nesting flag decides
// R09 - in-service level admits only stronger levels
// R10 - macro first, ordered by default priority
// R11 - context bank from vector even byte bits
// R12 - context entry swaps pc and status via bank
// R13 - bank return restores, stores immediate as entry
// R14 - bank irq return clears highest in-service bit
// R15 - stack trap always taken, fixed vector
// R16 - bank trap bank from second op-code byte
// R17 - soft bank return restores, stores next entry
// R18 - software must not bank-irq-return from traps
// R19 - bad protected write check byte raises trap
// R20 - op trap pushes faulting address, clears enable
// R21 - macro raises vectored after counted servicings
// R22 - stack irq return clears; trap returns keep
// R23 - reset sets level-3 nesting flag
// R24 - reset clears in-service bits
// R25 - arbitrate at boundaries, latch winner first
`default_nettype none
module irq_ack
  import irq_ack_pkg::*;
(
  input  wire logic            pclk,           // cpu clock
  input  wire logic            presetn,        // async reset, low
  input  wire logic [11:0]     paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [NREQ-1:0] irq_event,      // peripheral request pulses
  input  wire logic            instr_boundary, // core at instruction edge
  input  wire logic            op_valid,       // core instruction event
  input  wire op_e             op_kind,
  input  wire logic [15:0]     op_imm16,       // return immediate
  input  wire logic [2:0]      op_bank,        // bank operand
  input  wire logic [7:0]      op_data,        // protected write data
  input  wire logic [7:0]      op_check,       // protected write check
  input  wire logic [15:0]     op_start_pc,    // faulting instruction start
  input  wire logic            op_psw_ie,      // enable bit being restored
  input  wire logic            vec_byte_valid, // vector byte returned
  input  wire logic [7:0]      vec_byte,
  output logic                 vec_fetch,      // vector byte wanted
  output logic                 act_valid,      // one-cycle action pulse
  output act_e                 act_kind,
  output logic      [15:0]     act_addr,       // vector or fetch address
  output logic      [15:0]     act_pc,         // pushed or stored pc
  output logic      [2:0]      act_bank,
  output logic      [4:0]      act_src,
  output logic      [1:0]      act_level,
  output logic                 busy,           // core must hold events
  output logic                 global_irq_enable_flag,
  output logic      [3:0]      in_service_level_bits
);

  typedef enum logic [0:0] {ST_IDLE, ST_FETCH} st_e;

  // architectural state
  st_e             st_q;                       // entry sequencer
  logic [NREQ-1:0] req_q;                      // request flags
  logic [NREQ-1:0] mask_q;                     // mask flags
  logic [NREQ-1:0] mac_q;                      // macro service select
  logic [NREQ-1:0] ctx_q;                      // context switch select
  logic [NREQ-1:0] lvlo_q;                     // level low bits
  logic [NREQ-1:0] lvhi_q;                     // level high bits
  logic            nest_q;                     // level3_nesting_select
  logic [3:0]      isr_q;                      // in-service levels
  logic            ie_q;                       // global enable
  logic [7:0]      msc_q [NREQ];               // macro service counters
  logic [4:0]      src_q;                      // latched context winner
  logic [1:0]      lvl_q;                      // its level
  // apb answer registers
  logic [31:0]     rd_q;
  logic            rdy_q;
  logic            err_q;

  // apb decode
  wire setup  = psel & ~penable;
  wire access = psel & penable & rdy_q;
  wire wr     = access & pwrite & ~err_q;
  wire a_req  = paddr == OFS_REQ;
  wire a_mask = paddr == OFS_MASK;
  wire a_mac  = paddr == OFS_MACRO;
  wire a_ctx  = paddr == OFS_CTX;
  wire a_llo  = paddr == OFS_LVL_LO;
  wire a_lhi  = paddr == OFS_LVL_HI;
  wire a_mode = paddr == OFS_MODE;
  wire a_stat = paddr == OFS_STAT;
  wire a_msc  = (paddr >= OFS_MSC) && (paddr < OFS_MSC_END) && (paddr[1:0] == 2'b00);
  wire [11:0] msc_off = paddr - OFS_MSC;
  wire [4:0]  msc_idx = msc_off[6:2];
  wire a_hit  = a_req | a_mask | a_mac | a_ctx | a_llo | a_lhi | a_mode | a_stat | a_msc;
  // unmapped words answer with an error
  wire [31:0] rd_mux =
      a_req  ? {8'h00, req_q}  :
      a_mask ? {8'h00, mask_q} :
      a_mac  ? {8'h00, mac_q}  :
      a_ctx  ? {8'h00, ctx_q}  :
      a_llo  ? {8'h00, lvlo_q} :
      a_lhi  ? {8'h00, lvhi_q} :
      a_mode ? {31'h0, nest_q} :
      a_stat ? {27'h0, ie_q, isr_q} :
      a_msc  ? {24'h0, msc_q[msc_idx]} : 32'h0;

  // apb answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rd_q  <= 32'h0;
    end
    else
    begin
      rdy_q <= setup;
      err_q <= setup & ~a_hit;                 // error flag stands only with pready
      if (setup)
      begin
        rd_q  <= rd_mux;
      end
    end
  end

  // level acceptance per in-service state
  wire [NREQ-1:0] cand;                        // unmasked pending
  wire [NREQ-1:0] lvl_ok;                      // level admitted now
  genvar g;
  generate
    for (g = 0; g < NREQ; g++)
    begin : g_req
      wire [1:0] lv = {lvhi_q[g], lvlo_q[g]};  // R06
      assign cand[g] = req_q[g] & ~mask_q[g];  // R01
      assign lvl_ok[g] =                       // R07 R08 R09
          (isr_q == 4'h0) ? 1'b1 :
          isr_q[0] ? 1'b0 :
          isr_q[1] ? (lv == 2'd0) :
          isr_q[2] ? (lv < 2'd2) :
          ((lv < 2'd3) | ~nest_q);
    end
  endgenerate

  // macro requests ignore enable and level
  wire [NREQ-1:0] mac_cand = cand & mac_q;     // R02
  wire [NREQ-1:0] vec_cand = cand & ~mac_q & lvl_ok & {NREQ{ie_q}}; // R02 R07

  // winners; lower index is higher default priority
  logic [4:0] mw;                              // macro winner
  logic [4:0] vw;                              // vectored winner
  logic [1:0] vl;                              // its level
  always_comb
  begin
    mw = 5'd0;
    vw = 5'd0;
    vl = 2'd3;
    for (int i = NREQ - 1; i >= 0; i--)
    begin
      if (mac_cand[i])
        mw = 5'(i);                            // R10
      if (vec_cand[i] && ({lvhi_q[i], lvlo_q[i]} <= vl))
      begin
        vw = 5'(i);                            // R03
        vl = {lvhi_q[i], lvlo_q[i]};
      end
    end
  end

  // sequencing strobes
  wire idle     = st_q == ST_IDLE;
  wire op_go    = idle & op_valid;
  wire irq_slot = idle & instr_boundary & ~op_valid; // R25
  wire mac_go   = irq_slot & (|mac_cand);      // R10
  wire vec_go   = irq_slot & ~(|mac_cand) & (|vec_cand);
  wire ctx_go   = vec_go & ctx_q[vw];          // R11
  wire fet_done = (st_q == ST_FETCH) & vec_byte_valid;
  wire ent_go   = (vec_go & ~ctx_q[vw]) | fet_done;
  wire [4:0] ent_src = fet_done ? src_q : vw;
  wire [1:0] ent_lvl = fet_done ? lvl_q : vl;
  wire mac_last = msc_q[mw] <= 8'h01;          // R21
  wire bad_wr   = op_go & (op_kind == OP_PROT_WR) & (op_check != ~op_data); // R19
  wire isr_pop  = op_go & ((op_kind == OP_STACK_IRQ_RET) | (op_kind == OP_BANK_IRQ_RET)); // R14 R22
  wire ie_clr   = ent_go | bad_wr | (op_go & ((op_kind == OP_STACK_TRAP) |
                  (op_kind == OP_BANK_TRAP) | (op_kind == OP_DI)));
  wire ie_rst   = op_go & ((op_kind == OP_STACK_IRQ_RET) | (op_kind == OP_BANK_IRQ_RET) |
                  (op_kind == OP_SOFT_BANK_RET) | (op_kind == OP_STACK_TRAP_RET));

  // request flags: hardware set wins over every clear
  wire [NREQ-1:0] hw_clr = (ent_go ? (ONE_LSB << ent_src) : ZERO_RST) |
                           ((mac_go & ~mac_last) ? (ONE_LSB << mw) : ZERO_RST);
  wire [NREQ-1:0] sw_clr = (wr & a_req) ? pwdata[NREQ-1:0] : ZERO_RST;
  wire [NREQ-1:0] req_d  = (req_q & ~hw_clr & ~sw_clr) | irq_event; // R04
  // last servicing turns the request into a vectored one
  wire [NREQ-1:0] mac_fin = (mac_go & mac_last) ? (ONE_LSB << mw) : ZERO_RST;
  wire [NREQ-1:0] mac_d   = ((wr & a_mac) ? pwdata[NREQ-1:0] : mac_q) & ~mac_fin; // R21
  wire [3:0] isr_d = ent_go  ? (isr_q | (4'h1 << ent_lvl)) :  // R05
                     isr_pop ? (isr_q & (isr_q - 4'h1)) :     // R14 R22
                     isr_q;
  wire ie_d = ie_clr ? 1'b0 :                  // R05 R15 R20
              (op_go & (op_kind == OP_EI)) ? 1'b1 :
              ie_rst ? op_psw_ie : ie_q;

  // control and flag registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q  <= ZERO_RST;
      mask_q <= MASK_RST;
      mac_q  <= ZERO_RST;
      ctx_q  <= ZERO_RST;
      lvlo_q <= ZERO_RST;
      lvhi_q <= ZERO_RST;
      nest_q <= NEST_RST;                      // R23
      isr_q  <= ISR_RST;                       // R24
      ie_q   <= 1'b0;
    end
    else
    begin
      req_q <= req_d;
      mac_q <= mac_d;
      isr_q <= isr_d;
      ie_q  <= ie_d;
      if (wr & a_mask)
        mask_q <= pwdata[NREQ-1:0];
      if (wr & a_ctx)
        ctx_q <= pwdata[NREQ-1:0];
      if (wr & a_llo)
        lvlo_q <= pwdata[NREQ-1:0];
      if (wr & a_lhi)
        lvhi_q <= pwdata[NREQ-1:0];
      if (wr & a_mode)
        nest_q <= pwdata[MODE_NEST_BIT];
    end
  end

  // macro counters, one per request
  generate
    for (g = 0; g < NREQ; g++)
    begin : g_msc
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          msc_q[g] <= MSC_RST;
        else if (wr & a_msc & (msc_idx == 5'(g)))
          msc_q[g] <= pwdata[7:0];
        else if (mac_go & (mw == 5'(g)) & (msc_q[g] != MSC_RST))
          msc_q[g] <= msc_q[g] - 8'h01;        // R21
      end
    end
  endgenerate

  // entry sequencer: context entry waits for the vector byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= ST_IDLE;
      src_q <= 5'd0;
      lvl_q <= 2'd0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (ctx_go)
          begin
            st_q  <= ST_FETCH;                 // R25
            src_q <= vw;
            lvl_q <= vl;
          end
        ST_FETCH:
          if (vec_byte_valid)
            st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // action register toward the core
  logic act_v_q;
  act_e act_k_q;
  logic [15:0] act_a_q;
  logic [15:0] act_p_q;
  logic [2:0] act_b_q;
  logic [4:0] act_s_q;
  logic [1:0] act_l_q;
  logic fetch_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_v_q <= 1'b0;
      act_k_q <= ACT_NONE;
      act_a_q <= 16'h0;
      act_p_q <= 16'h0;
      act_b_q <= 3'd0;
      act_s_q <= 5'd0;
      act_l_q <= 2'd0;
      fetch_q <= 1'b0;
    end
    else
    begin
      act_v_q <= 1'b0;
      if (fet_done)
      begin
        fetch_q <= 1'b0;
        act_v_q <= 1'b1;
        act_k_q <= ACT_BANK_ENTRY;             // R12
        act_b_q <= vec_byte[2:0];              // R11
        act_s_q <= src_q;
        act_l_q <= lvl_q;
      end
      else if (op_go)
      begin
        act_b_q <= op_bank;
        act_p_q <= op_imm16;
        case (op_kind)
          OP_STACK_IRQ_RET, OP_STACK_TRAP_RET:
          begin
            act_v_q <= 1'b1;
            act_k_q <= ACT_STACK_RET;
          end
          OP_BANK_IRQ_RET, OP_SOFT_BANK_RET:
          begin
            act_v_q <= 1'b1;
            act_k_q <= ACT_BANK_RET;           // R13 R17
          end
          OP_STACK_TRAP:
          begin
            act_v_q <= 1'b1;
            act_k_q <= ACT_STACK_TRAP;         // R15
            act_a_q <= BRK_VEC;
          end
          OP_BANK_TRAP:
          begin
            act_v_q <= 1'b1;
            act_k_q <= ACT_BANK_TRAP;          // R16
          end
          OP_PROT_WR:
          begin
            act_v_q <= bad_wr;
            act_k_q <= ACT_OPTRAP;             // R20
            act_a_q <= OPTRAP_VEC;
            act_p_q <= op_start_pc;
          end
          default:
            act_k_q <= ACT_NONE;
        endcase
      end
      else if (mac_go)
      begin
        act_v_q <= 1'b1;
        act_k_q <= ACT_MACRO;                  // R02
        act_s_q <= mw;
      end
      else if (vec_go)
      begin
        act_v_q <= ~ctx_go;
        act_k_q <= ACT_VEC_ENTRY;              // R05
        act_a_q <= VEC_BASE + {10'h0, vw, 1'b0};
        act_s_q <= vw;
        act_l_q <= vl;
        fetch_q <= ctx_go;                     // R11
      end
    end
  end

  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign vec_fetch = fetch_q;
  assign act_valid = act_v_q;
  assign act_kind = act_k_q;
  assign act_addr = act_a_q;
  assign act_pc = act_p_q;
  assign act_bank = act_b_q;
  assign act_src = act_s_q;
  assign act_level = act_l_q;
  assign busy = st_q != ST_IDLE;
  assign global_irq_enable_flag = ie_q;
  assign in_service_level_bits = isr_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ctx_start;
    vec_go && ctx_go;
  endsequence
  sequence s_byte_back;
    vec_fetch && vec_byte_valid;
  endsequence

  chk_vec_entry_state: assert property ( // R05
    act_valid && act_kind == ACT_VEC_ENTRY |-> !ie_q && isr_q[act_level])
    else $error("vectored entry left enable or in-service wrong");
  chk_vec_needs_ie: assert property ( // R02
    act_valid && act_kind == ACT_VEC_ENTRY |-> $past(ie_q, 1))
    else $error("vectored entry taken with enable clear");
  chk_macro_first: assert property ( // R10
    irq_slot && (|mac_cand) |=> act_valid && act_kind == ACT_MACRO && act_src == $past(mw))
    else $error("macro request not served first");
  chk_idle_disabled: assert property ( // R07
    irq_slot && !ie_q && !(|mac_cand) |=> !act_valid && !vec_fetch)
    else $error("maskable entry while disabled");
  chk_isr_pop_high: assert property ( // R14
    op_go && op_kind == OP_BANK_IRQ_RET |=> isr_q == ($past(isr_q) & ($past(isr_q) - 4'h1)))
    else $error("bank irq return did not clear highest bit");
  chk_trap_ret_keep: assert property ( // R22
    op_go && (op_kind == OP_SOFT_BANK_RET || op_kind == OP_STACK_TRAP_RET) |=> $stable(isr_q))
    else $error("trap return changed in-service bits");
  chk_optrap_fire: assert property ( // R19
    op_go && op_kind == OP_PROT_WR && op_check != ~op_data
    |=> act_valid && act_kind == ACT_OPTRAP && act_pc == $past(op_start_pc) && !ie_q)
    else $error("op-code trap missing or wrong");
  chk_brk_vector: assert property ( // R15
    op_go && op_kind == OP_STACK_TRAP |=> act_valid && act_addr == BRK_VEC && !ie_q)
    else $error("stack trap vector wrong");
  chk_ctx_bank: assert property ( // R11
    s_ctx_start ##[2:20] s_byte_back |=> act_valid && act_kind == ACT_BANK_ENTRY &&
    act_bank == $past(vec_byte[2:0]))
    else $error("context bank not taken from vector byte");
  chk_bank_ret_imm: assert property ( // R13
    op_go && op_kind == OP_BANK_IRQ_RET |=> act_kind == ACT_BANK_RET && act_pc == $past(op_imm16))
    else $error("bank return immediate not passed");
  chk_nest_level3: assert property ( // R08
    act_valid && act_kind == ACT_VEC_ENTRY && $past(isr_q) == 4'h8 && $past(nest_q) |-> act_level != 2'd3)
    else $error("level 3 nested while nesting select set");

endmodule
`default_nettype wire

// ==== core_model.sv ====
// far-side model: answers even vector byte fetches after a set lag
`default_nettype none
module core_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       vec_fetch,      // byte wanted
  input  wire logic [7:0] bank_byte,      // even vector byte to give
  input  wire logic [3:0] lag,            // answer delay, 0 is prompt
  output logic            vec_byte_valid,
  output logic      [7:0] vec_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;                     // cycles spent waiting
  logic       done_q;                     // this fetch already answered
  // one answer per fetch; the line toggles otherwise so a stale byte never looks good
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wait_q         <= 4'h0;
      done_q         <= 1'b0;
      vec_byte_valid <= 1'b0;
      vec_byte       <= 8'h00;
    end
    else
    begin
      vec_byte_valid <= 1'b0;
      if (vec_fetch && !done_q && wait_q == lag)
      begin
        vec_byte_valid <= 1'b1;
        vec_byte       <= bank_byte;
        done_q         <= 1'b1;
      end
      else
      begin
        vec_byte <= ~vec_byte;            // released line
        wait_q   <= vec_fetch ? wait_q + 4'h1 : 4'h0;
        done_q   <= done_q & vec_fetch;
      end
    end
endmodule
`default_nettype wire

// ==== irq_ack_bench.sv ====
// self-checking bench for the interrupt acknowledge block
`default_nettype none
module irq_ack_bench
  import irq_ack_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, op_valid, op_psw_ie, instr_boundary;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NREQ-1:0] irq_event;
  op_e op_kind;
  act_e act_kind;
  logic [15:0] op_imm16, op_start_pc, act_addr, act_pc;
  logic [7:0] op_data, op_check, vec_byte, bank_byte;
  logic [2:0] op_bank, act_bank;
  logic [4:0] act_src;
  logic [1:0] act_level;
  logic [3:0] isr, lag, isr_was;
  logic vec_byte_valid, vec_fetch, act_valid, busy, ie, err;
  int miscompares, compares, n_act, nb;
  irq_ack irq_ack_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_event(irq_event), .instr_boundary(instr_boundary), .op_valid(op_valid), .op_kind(op_kind),
    .op_imm16(op_imm16), .op_bank(op_bank), .op_data(op_data), .op_check(op_check),
    .op_start_pc(op_start_pc), .op_psw_ie(op_psw_ie), .vec_byte_valid(vec_byte_valid),
    .vec_byte(vec_byte), .vec_fetch(vec_fetch), .act_valid(act_valid), .act_kind(act_kind),
    .act_addr(act_addr), .act_pc(act_pc), .act_bank(act_bank), .act_src(act_src),
    .act_level(act_level), .busy(busy), .global_irq_enable_flag(ie), .in_service_level_bits(isr));
  core_model core_model_inst (.pclk(pclk), .presetn(presetn), .vec_fetch(vec_fetch),
    .bank_byte(bank_byte), .lag(lag), .vec_byte_valid(vec_byte_valid), .vec_byte(vec_byte));
  // clock at 25 MHz
  always #20 pclk = ~pclk;
  // action counter; fields also change on events that raise no action
  always @(posedge pclk)
    if (act_valid === 1'b1)
      n_act++;
  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer; request held until pready seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      miscompares++;
      test_done();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // one core event, then time for the answer and any follow-up arbitration
  task automatic op(input op_e k, input logic [15:0] imm);
    nb = n_act;
    op_kind  <= k;
    op_imm16 <= imm;
    op_valid <= 1'b1;
    @(posedge pclk) op_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic ev(input logic [NREQ-1:0] m);
    nb = n_act;
    irq_event <= m;
    @(posedge pclk) irq_event <= ZERO_RST;
    repeat (10) @(posedge pclk);
  endtask
  // main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, op_valid, op_psw_ie} = '0;
    {paddr, pwdata, irq_event, op_imm16, op_start_pc, op_data, op_check, op_bank, bank_byte} = '0;
    {miscompares, compares, n_act} = '0;
    op_kind = OP_NONE;
    instr_boundary = 1'b1;
    lag = 4'h3;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_MASK, 0); chk(rd, 32'h00ffffff);
    apb(0, OFS_MODE, 0); chk(rd, 32'h1);
    apb(0, OFS_STAT, 0); chk(rd, 32'h0);
    apb(0, 12'h0fc, 0); chk(32'(err), 32'h1);
    $display("test reset done");
    apb(1, OFS_LVL_LO, 32'h0000a0);
    apb(1, OFS_LVL_HI, 32'h00000c);
    apb(1, OFS_MASK, 32'h00fffd43);
    op(OP_EI, 0); ev(24'h000040); chk(32'(n_act - nb), 0);
    op(OP_DI, 0); ev(24'h000008); chk(32'(n_act - nb), 0);
    op(OP_EI, 0); chk(32'(act_kind), 32'(ACT_VEC_ENTRY));
    chk(32'(act_src), 3); chk(32'(act_addr), 32'h0046);
    chk(32'(act_level), 2); chk(32'(ie), 0);
    apb(0, OFS_STAT, 0); chk(rd, 32'h4);
    $display("test vectored done");
    op(OP_EI, 0); ev(24'h0000a4); chk(32'(act_src), 5); chk(32'(isr), 4'h6);
    op(OP_EI, 0); chk(32'(n_act - nb), 0);
    op_psw_ie <= 1'b1;
    op(OP_STACK_IRQ_RET, 0); chk(32'(n_act - nb), 2);
    chk(32'(act_src), 7); chk(32'(isr), 4'h6);
    op_psw_ie <= 1'b0;
    op(OP_BANK_IRQ_RET, 16'hbeef); chk(32'(act_kind), 32'(ACT_BANK_RET));
    chk(32'(act_pc), 32'hbeef); chk(32'(isr), 4'h4);
    op(OP_STACK_IRQ_RET, 0); chk(32'(isr), 4'h0);
    apb(1, OFS_REQ, 32'h4);
    $display("test nesting done");
    apb(1, OFS_MACRO, 32'h0002a0);
    apb(1, 12'h064, 32'h2);
    apb(1, 12'h054, 32'h3);
    apb(1, 12'h05c, 32'h3);
    ev(24'h000200); chk(32'(act_kind), 32'(ACT_MACRO)); chk(32'(act_src), 9);
    ev(24'h000200); apb(0, OFS_MACRO, 0); chk(rd, 32'h0000a0);
    ev(24'h0000a0); chk(32'(n_act - nb), 2); chk(32'(act_src), 7);
    instr_boundary <= 1'b0;
    op(OP_EI, 0); chk(32'(n_act - nb), 0);
    instr_boundary <= 1'b1;
    op(OP_EI, 0); chk(32'(act_src), 9); chk(32'(act_addr), 32'h0052);
    op(OP_STACK_IRQ_RET, 0);
    $display("test macro done");
    apb(1, OFS_CTX, 32'h10);
    bank_byte <= 8'h2d;
    lag       <= 4'hf;
    op(OP_EI, 0); ev(24'h000010); chk(32'(busy), 1); chk(32'(vec_fetch), 1);
    op(OP_STACK_TRAP, 0); chk(32'(n_act - nb), 0);
    repeat (6) @(posedge pclk);
    chk(32'(act_kind), 32'(ACT_BANK_ENTRY));
    chk(32'(act_bank), 5); chk(32'(act_src), 4);
    $display("test context done");
    op(OP_STACK_TRAP, 0); chk(32'(act_addr), 32'h003e); chk(32'(ie), 0);
    op_bank <= 3'h6;
    op(OP_BANK_TRAP, 0); chk(32'(act_bank), 6);
    isr_was = isr;
    op(OP_SOFT_BANK_RET, 16'h1234); chk(32'(act_pc), 32'h1234);
    chk(32'(isr), 32'(isr_was));
    op_data     <= 8'ha5;
    op_check    <= 8'h5a;
    op_start_pc <= 16'h0100;
    op(OP_PROT_WR, 0); chk(32'(n_act - nb), 0);
    op_check <= 8'h5b;
    op(OP_PROT_WR, 0); chk(32'(act_kind), 32'(ACT_OPTRAP));
    chk(32'(act_pc), 32'h0100); chk(32'(act_addr), 32'(OPTRAP_VEC));
    $display("test traps done");
    op(OP_STACK_IRQ_RET, 0); chk(32'(isr), 4'h0);
    apb(1, OFS_LVL_LO, 32'h0018a0);
    apb(1, OFS_LVL_HI, 32'h00180c);
    apb(1, OFS_MASK, 32'h00ffe543);
    op(OP_EI, 0); ev(24'h000800); chk(32'(act_level), 3); chk(32'(isr), 4'h8);
    op(OP_EI, 0); ev(24'h001000); chk(32'(n_act - nb), 0);
    apb(1, OFS_MODE, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(act_src), 12); chk(32'(isr), 4'h8);
    $display("test level3 done");
    test_done();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
